// ---- logic/dce_engine.sv ----
/*
 four-channel transfer engine with its AHB-Lite register slave.
 assumes one system bus grant, synchronous peripheral pins and a
 single-master zero-wait register bus; word accesses only.
*/
`timescale 1ns/100ps
module dce_engine
	import dce_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] chan_request_n,
	output logic [3:0] chan_acknowledge_n,
	input wire logic [3:0] periph_control_line,
	output logic [3:0] chan_irq,
	output logic sys_bus_req,
	input wire logic sys_bus_grant,
	output logic sys_own_n,
	output logic [23:0] sys_addr,
	output logic sys_rd,
	output logic sys_wr,
	output logic sys_byte,
	output logic [15:0] sys_wdata,
	output logic sys_wdata_oe,
	input wire logic [15:0] sys_rdata,
	input wire logic sys_ready
);
	// illegal combinations refuse the start
	function automatic logic cfg_bad(input logic [7:0] d, input logic [7:0] o);
		logic [1:0] rq;
		logic [1:0] sz;
		logic sgl;
		rq = o[OCR_REQUEST_GENERATION_FIELD +: 2];
		sz = o[OCR_SIZE +: 2];
		sgl = d[DCR_DEVICE_TYPE_FIELD + 1];
		cfg_bad = (rq == 2'h3) | (sz == 2'h3) |
			((rq == RQ_EXT) & (d[DCR_XRM +: 2] == XRM_RSVD)) |
			(~sgl & (rq == RQ_EXT)) |
			(sgl & ((sz == SZ_LONG) | (d[DCR_PORT16] != (sz == SZ_WORD))));
	endfunction

	// index of the last operand part
	function automatic logic [1:0] last_part(input logic [1:0] sz,
		input logic p16);
		if (p16) begin
			last_part = (sz == SZ_LONG) ? 2'h1 : 2'h0;
		end else begin
			last_part = (sz == SZ_LONG) ? 2'h3 : (sz == SZ_WORD) ? 2'h1 : 2'h0;
		end
	endfunction

	// lowest ready channel wins
	function automatic logic [1:0] first_ch(input logic [3:0] r);
		first_ch = r[0] ? 2'h0 : r[1] ? 2'h1 : r[2] ? 2'h2 : 2'h3;
	endfunction

	logic bw_q;
	logic bok_q;
	logic [8:0] ba_q;
	logic [31:0] hrdata_q;
	logic [15:0] gcr_q;
	logic [7:0] rate_q;
	dce_state_t st_q, st_d;
	logic [1:0] cur_q;
	logic [1:0] part_q;
	logic [7:0] hcnt_q;
	logic [15:0] hold_q [4];
	logic take;
	logic op_done;
	logic [3:0] pcl_lvl;
	logic [3:0] pcl_fall;
	logic [7:0] dcr_w [4];
	logic [7:0] ocr_w [4];
	logic [7:0] scr_w [4];
	logic [31:0] mar_w [4];
	logic [31:0] dar_w [4];
	logic [31:0] rdv_w [4];
	logic [3:0] act_w;
	logic [3:0] pend_w;
	logic [31:0] mar_nx;
	logic [31:0] dar_nx;

	// register bus decode
	wire ahb_go = hsel & htrans[1] & hready;
	wire bus_wr = bw_q & bok_q;
	wire gcr_rd = haddr == GCR_ADDR;
	wire chan_rd = haddr[31:8] == 24'h0;
	wire [31:0] rd_val = chan_rd ? rdv_w[haddr[7:6]] :
		gcr_rd ? {16'h0, gcr_q} : 32'h0;
	wire gcr_we = bus_wr & (ba_q == GCR_ADDR[8:0]);
	wire rate_tick = rate_q >= gcr_q[GCR_RATE +: 8];

	// address phase capture, read data registered for the data phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bw_q <= 1'b0;
			bok_q <= 1'b0;
			ba_q <= 9'h000;
			hrdata_q <= 32'h0;
		end else if (ce) begin
			bw_q <= ahb_go & hwrite & (hsize == 3'h2);
			if (ahb_go) begin
				bok_q <= haddr[31:9] == 23'h0;
				ba_q <= haddr[8:0];
			end
			if (ahb_go & ~hwrite) begin
				hrdata_q <= rd_val;
			end
		end
	end

	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// general control and limited-rate tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gcr_q <= GCR_RST;
			rate_q <= 8'h00;
		end else if (ce) begin
			if (gcr_we) begin
				gcr_q <= hwdata[15:0];
			end
			rate_q <= rate_tick ? 8'h00 : rate_q + 8'h01;
		end
	end

	// one channel register set per loop pass
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [7:0] dcr_q, ocr_q, scr_q;
		logic [31:0] mar_q, dar_q, bar_q;
		logic [15:0] mtc_q, btc_q;
		logic ien_q, pct_q, act_q, coc_q, err_q, pend_q, rqp_q;
		logic [31:0] rdv;
		wire we = bus_wr & (ba_q[8:6] == {1'b0, 2'(c)});
		wire [5:0] wo = ba_q[5:0];
		wire upd = op_done & (cur_q == 2'(c));
		wire [1:0] dt = dcr_q[DCR_DEVICE_TYPE_FIELD +: 2];
		wire [2:0] pf = dcr_q[DCR_PFN +: 3];
		wire [1:0] external_request_mode_field = dcr_q[DCR_XRM +: 2];
		wire [1:0] rqg = ocr_q[OCR_REQUEST_GENERATION_FIELD +: 2];
		// sync and ready types take the line over
		wire fn_on = (dt != DT_SYNC8) & (dt != DT_ACKRDY);
		// abort counts only on a running channel
		wire abort = fn_on & (pf == PF_ABORT) & act_q & pcl_fall[c];
		wire start = we & (wo == OFS_CCR) & hwdata[CCR_START] & ~act_q;
		wire bad = cfg_bad(dcr_q, ocr_q);
		wire cnt0 = mtc_q == 16'h0;
		wire last = upd & (mtc_q == 16'h1);
		wire clr = we & (wo == OFS_CSR);
		wire ext_ev = (external_request_mode_field == XRM_BURST) ? ~chan_request_n[c] :
			rqp_q & ~chan_request_n[c];
		wire rq_ev = (rqg == RQ_EXT) ? ext_ev :
			(rqg == RQ_MAX) | rate_tick;
		wire take_c = take & (cur_q == 2'(c));

		// configuration and base registers
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				dcr_q <= CFG_RST;
				ocr_q <= CFG_RST;
				scr_q <= CFG_RST;
				ien_q <= 1'b0;
				bar_q <= ADDR_RST;
				btc_q <= CNT_RST;
			end else if (ce & we) begin
				case (wo)
					OFS_DCR: dcr_q <= hwdata[7:0];
					OFS_OCR: ocr_q <= hwdata[7:0];
					OFS_SCR: scr_q <= hwdata[7:0];
					OFS_CCR: ien_q <= hwdata[CCR_IEN];
					OFS_BAR: bar_q <= hwdata;
					OFS_BTC: btc_q <= hwdata[15:0];
					default: ;
				endcase
			end
		end

		// addresses and count move after the operand
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				mar_q <= ADDR_RST;
				dar_q <= ADDR_RST;
				mtc_q <= CNT_RST;
			end else if (ce) begin
				if (upd) begin
					mar_q <= mar_nx;
					dar_q <= dar_nx;
					mtc_q <= mtc_q - 16'h1;
				end else if (we & (wo == OFS_MAR)) begin
					mar_q <= hwdata;
				end else if (we & (wo == OFS_DAR)) begin
					dar_q <= hwdata;
				end else if (we & (wo == OFS_MTC)) begin
					mtc_q <= hwdata[15:0];
				end
			end
		end

		// status flags, a set wins over a clear
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				pct_q <= 1'b0;
				act_q <= 1'b0;
				coc_q <= 1'b0;
				err_q <= 1'b0;
				pend_q <= 1'b0;
				rqp_q <= 1'b1;
			end else if (ce) begin
				pct_q <= (fn_on & (pf != PF_ABORT) & pcl_fall[c]) |
					(pct_q & ~(clr & hwdata[CSR_TRANS]));
				if (start) begin
					act_q <= ~bad & ~cnt0;
				end else if (last | abort) begin
					act_q <= 1'b0;
				end
				coc_q <= last | abort | (coc_q & ~(clr & hwdata[CSR_DONE]));
				err_q <= (start & (bad | cnt0)) | abort |
					(err_q & ~(clr & hwdata[CSR_ERR]));
				pend_q <= act_q & (rq_ev | (pend_q & ~take_c));
				rqp_q <= chan_request_n[c];
			end
		end

		// readback; live line level in status
		always_comb begin
			rdv = 32'h0;
			case (haddr[5:0])
				OFS_CSR: begin
					rdv[CSR_LEVEL] = fn_on & (pf == PF_STATUS) & pcl_lvl[c];
					rdv[CSR_TRANS] = pct_q;
					rdv[CSR_ACT] = act_q;
					rdv[CSR_DONE] = coc_q;
					rdv[CSR_ERR] = err_q;
				end
				OFS_DCR: rdv = {24'h0, dcr_q};
				OFS_OCR: rdv = {24'h0, ocr_q};
				OFS_SCR: rdv = {24'h0, scr_q};
				OFS_CCR: rdv[CCR_IEN] = ien_q;
				OFS_MAR: rdv = mar_q;
				OFS_DAR: rdv = dar_q;
				OFS_BAR: rdv = bar_q;
				OFS_MTC: rdv = {16'h0, mtc_q};
				OFS_BTC: rdv = {16'h0, btc_q};
				default: rdv = 32'h0;
			endcase
		end

		assign dcr_w[c] = dcr_q;
		assign ocr_w[c] = ocr_q;
		assign scr_w[c] = scr_q;
		assign mar_w[c] = mar_q;
		assign dar_w[c] = dar_q;
		assign rdv_w[c] = rdv;
		assign act_w[c] = act_q;
		assign pend_w[c] = pend_q;
		assign chan_irq[c] = ien_q & pct_q;

		dce_pcl_mon u_mon (
			.clk(clk),
			.sys_rst(sys_rst),
			.ce(ce),
			.line(periph_control_line[c]),
			.level(pcl_lvl[c]),
			.fall(pcl_fall[c])
		);
	end

	// settings of the channel on the bus
	wire [7:0] k_dcr = dcr_w[cur_q];
	wire [7:0] k_ocr = ocr_w[cur_q];
	wire [7:0] k_scr = scr_w[cur_q];
	wire [1:0] k_dt = k_dcr[DCR_DEVICE_TYPE_FIELD +: 2];
	// high type bit means single addressing
	wire k_sgl = k_dt[1];
	wire k_dir = k_ocr[OCR_DIR];
	wire k_p16 = k_dcr[DCR_PORT16];
	wire [1:0] k_sz = k_ocr[OCR_SIZE +: 2];
	wire [1:0] k_xrm = k_dcr[DCR_XRM +: 2];
	// mode field only counts for external requests
	wire k_ext = k_ocr[OCR_REQUEST_GENERATION_FIELD +: 2] == RQ_EXT;
	wire k_burst = k_ext ? (k_xrm == XRM_BURST) :
		(k_ocr[OCR_REQUEST_GENERATION_FIELD +: 2] == RQ_MAX);
	wire k_hold = k_ext & (k_xrm == XRM_HOLD);
	wire [1:0] k_last = last_part(k_sz, k_p16);
	wire [2:0] k_step = (k_sz == SZ_LONG) ? 3'h4 :
		(k_sz == SZ_WORD) ? 3'h2 : 3'h1;
	wire [3:0] rdy = act_w & pend_w;
	wire k_rdy = rdy[cur_q];
	wire in_rd = st_q == ST_RD;
	wire in_wr = st_q == ST_WR;
	wire in_fly = st_q == ST_FLY;
	wire [31:0] src_a = k_dir ? dar_w[cur_q] : mar_w[cur_q];
	wire [31:0] dst_a = k_dir ? mar_w[cur_q] : dar_w[cur_q];
	wire [31:0] part_a = (in_rd ? src_a : dst_a) + {29'h0, part_q, 1'b0};
	wire dev_acc = (in_rd & k_dir) | (in_wr & ~k_dir);
	wire line_lo = ~periph_control_line[cur_q];
	// enable for sync device, ready for ready device
	wire pcl_ok = ((k_dt == DT_SYNC8) & dev_acc) ? line_lo :
		((k_dt == DT_ACKRDY) & in_fly) ? line_lo : 1'b1;
	wire cyc_ok = sys_ready & pcl_ok;
	wire part_end = part_q == k_last;
	wire hold_end = hcnt_q >= gcr_q[GCR_HOLD +: 8];
	wire [1:0] mem_mode = k_scr[SCR_MEM +: 2];
	wire [1:0] dev_mode = k_sgl ? SQ_HOLD : k_scr[SCR_DEV +: 2];

	// engine sequence
	always_comb begin
		st_d = st_q;
		take = 1'b0;
		op_done = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (|rdy) begin
					st_d = ST_ARB;
				end
			end
			ST_ARB: begin
				if (~act_w[cur_q]) begin
					st_d = ST_IDLE;
				end else if (sys_bus_grant) begin
					take = 1'b1;
					st_d = k_sgl ? ST_FLY : ST_RD;
				end
			end
			ST_RD: begin
				if (cyc_ok & part_end) begin
					st_d = ST_WR;
				end
			end
			ST_WR: begin
				if (cyc_ok & part_end) begin
					op_done = 1'b1;
					st_d = ST_NEXT;
				end
			end
			ST_FLY: begin
				if (cyc_ok) begin
					op_done = 1'b1;
					st_d = ST_NEXT;
				end
			end
			// keep, hold or release the bus
			ST_NEXT: begin
				if (k_rdy & k_burst) begin
					take = 1'b1;
					st_d = k_sgl ? ST_FLY : ST_RD;
				end else if (k_hold & act_w[cur_q]) begin
					st_d = ST_HOLD;
				end else begin
					st_d = ST_IDLE;
				end
			end
			// new request within the hold period
			ST_HOLD: begin
				if (k_rdy) begin
					take = 1'b1;
					st_d = k_sgl ? ST_FLY : ST_RD;
				end else if (hold_end | ~act_w[cur_q]) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// engine registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			cur_q <= 2'h0;
			part_q <= 2'h0;
			hcnt_q <= 8'h00;
		end else if (ce) begin
			st_q <= st_d;
			if (st_q == ST_IDLE) begin
				cur_q <= first_ch(rdy);
			end
			if (st_d != st_q) begin
				part_q <= 2'h0;
			end else if (cyc_ok & (in_rd | in_wr)) begin
				part_q <= part_q + 2'h1;
			end
			hcnt_q <= (st_q == ST_HOLD) ? hcnt_q + 8'h01 : 8'h00;
		end
	end

	// holding registers, narrow port in low byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				hold_q[i] <= 16'h0000;
			end
		end else if (ce & in_rd & cyc_ok) begin
			hold_q[part_q] <= k_p16 ? sys_rdata : {8'h00, sys_rdata[7:0]};
		end
	end

	dce_step u_mar (
		.addr(mar_w[cur_q]),
		.mode(mem_mode),
		.step(k_step),
		.nxt(mar_nx)
	);

	dce_step u_dar (
		.addr(dar_w[cur_q]),
		.mode(dev_mode),
		.step(k_step),
		.nxt(dar_nx)
	);

	assign sys_bus_req = st_q == ST_ARB;
	assign sys_own_n = (st_q == ST_IDLE) | (st_q == ST_ARB);
	assign sys_addr = in_fly ? mar_w[cur_q][23:0] :
		(in_rd | in_wr) ? part_a[23:0] : 24'h000000;
	assign sys_rd = in_rd | (in_fly & ~k_dir);
	assign sys_wr = in_wr | (in_fly & k_dir);
	assign sys_byte = in_fly ? (k_sz == SZ_BYTE) : ~k_p16;
	assign sys_wdata = in_wr ? hold_q[part_q] : 16'h0000;
	assign sys_wdata_oe = in_wr;

	for (genvar a = 0; a < NCH; a++) begin : g_ack
		assign chan_acknowledge_n[a] = ~(in_fly & (cur_q == 2'(a)));
	end
endmodule

// ---- logic/dce_pkg.sv ----
/*
 package of the four-channel transfer engine: register offsets, field
 positions, codes, reset values and the one-hot engine states.
 assumes one clock domain and a 32-bit register bus with word access.
*/
//
// Overview of operation
// - four channels; 24-bit address, 16-bit data as system bus master
// - memory-to-memory needs automatic requests; acknowledge never asserted
// - sync type uses line as enable, ready type as ready
// - line function watched except for sync and ready types; abort only counts once channel runs
// - status function: status bit shows present line level
// - falling edge low two cycles sets transition bit; interrupt if enabled
// - request field picks external (10), automatic max or limited rate
// - external mode field: burst (00), cycle steal, steal with hold
// - steal: request falling edge, arbitrate bus, then acknowledge operand
// - no hold releases bus each operand; hold waits general period
// - device type 00/01 dual addressing, 10/11 single addressing
// - dual: read source into holding registers, then write destination
// - single: one bus cycle per operand, no holding registers
// - device control selects 8 or 16 bit port width
// - operand byte, word, long; several cycles if wider than port
// - memory address counts up, down or hold; device address likewise in dual, always held in single
// - single: memory address steps 1 byte, 2 word; update after operand
// - dual parts ascend by two; parts = size/port; step applied after
// - three 32-bit address registers per channel: memory, device, base
// - 16-bit memory counter minus one per operand; 16-bit base counter
// - zero is terminal count; starting with zero count flags count error
// - start bit activates channel at once, ready for requests
package dce_pkg;
	localparam int NCH = 4;
	// channel block stride is 0x40, general control sits above
	localparam logic [5:0] OFS_CSR = 6'h00;
	localparam logic [5:0] OFS_DCR = 6'h04;
	localparam logic [5:0] OFS_OCR = 6'h08;
	localparam logic [5:0] OFS_SCR = 6'h0C;
	localparam logic [5:0] OFS_CCR = 6'h10;
	localparam logic [5:0] OFS_MAR = 6'h14;
	localparam logic [5:0] OFS_DAR = 6'h18;
	localparam logic [5:0] OFS_BAR = 6'h1C;
	localparam logic [5:0] OFS_MTC = 6'h20;
	localparam logic [5:0] OFS_BTC = 6'h24;
	localparam logic [31:0] GCR_ADDR = 32'h0000_0100;
	// field positions
	localparam int DCR_XRM = 0;
	localparam int DCR_DEVICE_TYPE_FIELD = 2;
	localparam int DCR_PORT16 = 4;
	localparam int DCR_PFN = 5;
	localparam int OCR_REQUEST_GENERATION_FIELD = 0;
	localparam int OCR_SIZE = 2;
	localparam int OCR_DIR = 4;
	localparam int SCR_MEM = 0;
	localparam int SCR_DEV = 2;
	localparam int CCR_START = 0;
	localparam int CCR_IEN = 1;
	localparam int CSR_LEVEL = 0;
	localparam int CSR_TRANS = 1;
	localparam int CSR_ACT = 2;
	localparam int CSR_DONE = 3;
	localparam int CSR_ERR = 4;
	localparam int GCR_HOLD = 0;
	localparam int GCR_RATE = 8;
	// codes
	localparam logic [1:0] XRM_BURST = 2'h0;
	localparam logic [1:0] XRM_RSVD = 2'h1;
	localparam logic [1:0] XRM_STEAL = 2'h2;
	localparam logic [1:0] XRM_HOLD = 2'h3;
	localparam logic [1:0] DT_BUS16 = 2'h0;
	localparam logic [1:0] DT_SYNC8 = 2'h1;
	localparam logic [1:0] DT_ACK = 2'h2;
	localparam logic [1:0] DT_ACKRDY = 2'h3;
	localparam logic [1:0] RQ_LIMIT = 2'h0;
	localparam logic [1:0] RQ_MAX = 2'h1;
	localparam logic [1:0] RQ_EXT = 2'h2;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [1:0] SQ_HOLD = 2'h0;
	localparam logic [1:0] SQ_UP = 2'h1;
	localparam logic [1:0] SQ_DOWN = 2'h2;
	localparam logic [2:0] PF_STATUS = 3'h0;
	localparam logic [2:0] PF_IRQ = 3'h1;
	localparam logic [2:0] PF_READY = 3'h2;
	localparam logic [2:0] PF_ENABLE = 3'h3;
	localparam logic [2:0] PF_ABORT = 3'h4;
	// reset values and timing
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] GCR_RST = 16'h1008;
	localparam int PCL_LOW_CYC = 2;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ARB = 7'h02,
		ST_RD = 7'h04,
		ST_WR = 7'h08,
		ST_FLY = 7'h10,
		ST_NEXT = 7'h20,
		ST_HOLD = 7'h40
	} dce_state_t;
endpackage

// ---- logic/dce_pcl_mon.sv ----
/*
 watcher of one peripheral control line: level and a filtered fall.
 assumes the line is synchronous to clk and idles high.
*/
`timescale 1ns/100ps
module dce_pcl_mon
	import dce_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic line,
	output logic level,
	output logic fall
);
	logic [PCL_LOW_CYC:0] hist_q;
	localparam logic [PCL_LOW_CYC:0] FALL_PAT = {1'b1, {PCL_LOW_CYC{1'b0}}};

	// shift history, resets high so no false edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hist_q <= '1;
		end else if (ce) begin
			hist_q <= {hist_q[PCL_LOW_CYC-1:0], line};
		end
	end

	assign level = line;
	assign fall = ce & (hist_q == FALL_PAT);
endmodule

// ---- logic/dce_step.sv ----
/*
 address stepper: counts an address up, down or holds it.
 assumes a byte step of 1, 2 or 4 from the caller.
*/
`timescale 1ns/100ps
module dce_step
	import dce_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [1:0] mode,
	input wire logic [2:0] step,
	output logic [31:0] nxt
);
	wire [31:0] st32 = {29'h0, step};

	assign nxt = (mode == SQ_UP) ? addr + st32 :
		(mode == SQ_DOWN) ? addr - st32 : addr;
endmodule

// ---- verification/dce_periph_model.sv ----
/*
 byte-wide peripheral on channel 0, a memory that completes every bus
 cycle, and a one-master bus arbiter.
 assumes the engine holds each strobe until the cycle completes.
*/
`timescale 1ns/100ps
module dce_periph_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic ack_n,
	input wire logic sys_bus_req,
	input wire logic sys_rd,
	input wire logic sys_wr,
	input wire logic [23:0] sys_addr,
	input wire logic sys_byte,
	input wire logic [15:0] sys_wdata,
	output logic req_n,
	output logic grant,
	output logic ready,
	output logic [15:0] rdata,
	output logic [3:0] count,
	output logic [23:0] last_addr,
	output logic [15:0] last_wdata,
	output logic last_byte
);
	logic [15:0] pat_q;
	// data only valid in the completing cycle, else a moving pattern
	assign rdata = ready ? 16'h5AA5 : pat_q;
	// request, grant and cycle completion
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_n <= 1'b1;
			grant <= 1'b0;
			ready <= 1'b0;
			count <= 4'h0;
			pat_q <= 16'h0000;
			last_addr <= 24'h000000;
			last_wdata <= 16'h0000;
			last_byte <= 1'b0;
		end else begin
			pat_q <= pat_q + 16'h1357;
			grant <= sys_bus_req; // one cycle to win the bus
			if (go)
				req_n <= 1'b0;
			else if (!ack_n)
				req_n <= 1'b1;
			// complete each strobe a cycle later, one part every two cycles
			ready <= (sys_rd || sys_wr) && !ready;
			if (ready) begin
				count <= count + 4'h1;
				last_addr <= sys_addr;
				last_byte <= sys_byte;
			end
			if (ready && sys_wr)
				last_wdata <= sys_wdata;
		end
	end
endmodule

// ---- verification/dce_engine_checker.sv ----
/*
 port checker of the transfer engine, bound into dce_engine.
 assumes one clock domain with synchronous reset sys_rst.
*/
`timescale 1ns/100ps
module dce_engine_checker
	import dce_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [3:0] chan_acknowledge_n,
	input wire logic [3:0] chan_irq,
	input wire logic sys_bus_req,
	input wire logic sys_bus_grant,
	input wire logic sys_own_n,
	input wire logic [23:0] sys_addr,
	input wire logic sys_rd,
	input wire logic sys_wr,
	input wire logic sys_wdata_oe,
	input wire logic sys_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_bus_okay: assert property (hreadyout == ce && hresp == 1'b0)
		else $error("register bus answer wrong");
	a_ack_single: assert property ($onehot0(~chan_acknowledge_n))
		else $error("two acknowledges at once");
	a_ack_strobe: assert property (chan_acknowledge_n != 4'hF |->
		(sys_rd ^ sys_wr) && !sys_own_n)
		else $error("acknowledge without one strobe");
	a_oe_noack: assert property (sys_wdata_oe |->
		chan_acknowledge_n == 4'hF && sys_wr)
		else $error("dual write with acknowledge");
	a_req_wait: assert property (ce && sys_bus_req && !sys_bus_grant |=>
		sys_bus_req)
		else $error("bus request dropped before grant");
	a_strobe_hold: assert property (ce && (sys_rd || sys_wr) && !sys_ready
		|=> $stable(sys_addr) && (sys_rd || sys_wr))
		else $error("bus cycle changed before ready");
	a_strobe_own: assert property ((sys_rd || sys_wr) |-> !sys_own_n)
		else $error("strobe without bus ownership");
	a_rst_idle: assert property ($fell(sys_rst) |->
		chan_acknowledge_n == 4'hF && sys_own_n && !sys_bus_req
		&& chan_irq == 4'h0)
		else $error("activity right after reset");
endmodule
bind dce_engine dce_engine_checker dce_engine_checker_i (.clk(clk),
	.sys_rst(sys_rst), .ce(ce), .hreadyout(hreadyout), .hresp(hresp),
	.chan_acknowledge_n(chan_acknowledge_n), .chan_irq(chan_irq),
	.sys_bus_req(sys_bus_req), .sys_bus_grant(sys_bus_grant),
	.sys_own_n(sys_own_n), .sys_addr(sys_addr), .sys_rd(sys_rd),
	.sys_wr(sys_wr), .sys_wdata_oe(sys_wdata_oe), .sys_ready(sys_ready));

// ---- verification/dce_engine_tb.sv ----
/*
 testbench of the transfer engine: register access, line status,
 single-address steal and hold transfers and a dual-address copy.
 assumes the peripheral model on channel 0.
*/
`timescale 1ns/100ps
module dce_engine_tb;
	import dce_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic go = 1'b0, hreadyout, hresp, sys_bus_req, sys_bus_grant, sys_own_n;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] pcl = 4'hF, ack_n, irq, cnt, base;
	logic chan_request_n_n, sys_rd, sys_wr, sys_byte, oe, ready, lbyte;
	logic [23:0] sys_addr, last_addr;
	logic [15:0] wdata, rdata, lwdata;
	int failures = 0, samples_checked = 0, cyc = 0;
	always #2 clk = ~clk;
	dce_engine dce_engine_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.chan_request_n({3'h7, chan_request_n_n}), .chan_acknowledge_n(ack_n),
		.periph_control_line(pcl), .chan_irq(irq), .sys_bus_req(sys_bus_req),
		.sys_bus_grant(sys_bus_grant), .sys_own_n(sys_own_n),
		.sys_addr(sys_addr), .sys_rd(sys_rd), .sys_wr(sys_wr),
		.sys_byte(sys_byte), .sys_wdata(wdata), .sys_wdata_oe(oe),
		.sys_rdata(rdata), .sys_ready(ready));
	dce_periph_model dce_periph_model_i (.clk(clk), .sys_rst(sys_rst),
		.go(go), .ack_n(ack_n[0]), .sys_bus_req(sys_bus_req), .sys_rd(sys_rd),
		.sys_wr(sys_wr), .sys_addr(sys_addr), .sys_byte(sys_byte),
		.sys_wdata(wdata), .req_n(chan_request_n_n),
		.grant(sys_bus_grant), .ready(ready), .rdata(rdata), .count(cnt),
		.last_addr(last_addr), .last_wdata(lwdata), .last_byte(lbyte));
	task results;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one AHB-Lite single word transfer, read data taken at data edge
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task rd(input logic [31:0] a);
		ahb(1'b0, a, 32'h0);
	endtask
	// single transfers of n bytes, memory count mode and steal mode
	task xfer(input logic [1:0] m, input logic [1:0] x, input logic [31:0] memory_address_reg,
		input int n);
		logic [31:0] st;
		st = (m == SQ_UP) ? 32'h1 : (m == SQ_DOWN) ? 32'hFFFF_FFFF : 32'h0;
		ahb(1'b1, OFS_DCR, {28'h0, DT_ACK, x});
		ahb(1'b1, OFS_OCR, {30'h0, RQ_EXT});
		ahb(1'b1, OFS_SCR, {30'h0, m});
		ahb(1'b1, OFS_MAR, memory_address_reg);
		ahb(1'b1, OFS_MTC, n);
		ahb(1'b1, OFS_CCR, 32'h1);
		rd(OFS_CSR);
		check(rv, 32'h05);
		base = cnt;
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			check(sys_own_n, k == 0 || x != XRM_HOLD);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			while (cnt != base + k[3:0] + 4'h1) @(posedge clk);
			check({8'h0, last_addr}, memory_address_reg + k * st);
			check(lbyte, 1'b1);
		end
		repeat (3) @(posedge clk);
		rd(OFS_CSR);
		check(rv, 32'h09);
		rd(OFS_MAR);
		check(rv, memory_address_reg + n * st);
		rd(OFS_MTC);
		check(rv, 32'h0);
		ahb(1'b1, OFS_CSR, 32'h1F);
	endtask
	// cycle ceiling against hangs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			results;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(GCR_ADDR);
		check(rv, {16'h0, GCR_RST});
		rd(32'h180);
		check(rv, 32'h0);
		ahb(1'b1, OFS_BAR, 32'hDEAD_BEEF);
		rd(OFS_BAR);
		check(rv, 32'hDEAD_BEEF);
		ahb(1'b1, OFS_BTC, 32'h0000_ABCD);
		rd(OFS_BTC);
		check(rv, 32'h0000_ABCD);
		// start with a zero count is refused
		ahb(1'b1, OFS_CCR, 32'h1);
		rd(OFS_CSR);
		check(rv, 32'h11);
		ahb(1'b1, OFS_CSR, 32'h1F);
		// status line level and filtered fall on channel 1
		pcl[1] <= 1'b0;
		repeat (4) @(posedge clk);
		rd(32'h40);
		check(rv, 32'h02);
		ahb(1'b1, 32'h50, 32'h2);
		@(posedge clk);
		check(irq, 4'h2);
		pcl[1] <= 1'b1;
		rd(32'h40);
		check(rv, 32'h03);
		ahb(1'b1, 32'h40, 32'h2);
		@(posedge clk);
		check(irq, 4'h0);
		xfer(SQ_UP, XRM_STEAL, 32'h100, 2);
		xfer(SQ_DOWN, XRM_STEAL, 32'h200, 2);
		xfer(SQ_HOLD, XRM_HOLD, 32'h300, 2);
		// dual long copy, automatic max rate, 16-bit port
		ahb(1'b1, OFS_DCR, 32'h10);
		ahb(1'b1, OFS_OCR, {28'h0, SZ_LONG, RQ_MAX});
		ahb(1'b1, OFS_SCR, {28'h0, SQ_UP, SQ_UP});
		ahb(1'b1, OFS_MAR, 32'h400);
		ahb(1'b1, OFS_DAR, 32'h800);
		ahb(1'b1, OFS_MTC, 32'h2);
		base = cnt;
		ahb(1'b1, OFS_CCR, 32'h1);
		while (cnt != base + 4'h8) @(posedge clk);
		check({8'h0, last_addr}, 32'h806);
		check(lwdata, 32'h5AA5);
		check(lbyte, 1'b0);
		rd(OFS_MAR);
		check(rv, 32'h408);
		rd(OFS_DAR);
		check(rv, 32'h808);
		rd(OFS_CSR);
		check(rv, 32'h09);
		results;
	end
endmodule
